//--- bench/sol_host_model.sv
// Behavioural host on the serial link: answers COMINIT with COMWAKE and echoes ALIGN.
// Assumes the bench calls oob() for host resets and drives answer and ans_spd.
`timescale 1ns/1ps
module sol_host_model
	import sol_pkg::*;
(
	input wire logic clk,
	input wire sol_tx_ctl_t tx_ctl,
	input wire logic answer,
	input wire logic [SPD_W-1:0] ans_spd,
	output logic rx_burst,
	output sol_rx_prim_t rx_prim,
	output logic rx_locked
);
	int lo = 999;
	int nb = 0;
	logic [1:0] ph = 2'h0;
	logic ans;
	logic sending = 1'b0;
	// Fixed-length bursts with the caller's gap between them, then a quiet line long enough to mark the end.
	task automatic oob(input int n, input int gap);
		sending = 1'b1;
		for (int i = 0; i < n; i++) begin
			rx_burst = 1'b1;
			repeat (BURST_CYC) @(negedge clk);
			rx_burst = 1'b0;
			repeat (i == n - 1 ? QUIET_CYC : gap) @(negedge clk);
		end
		sending = 1'b0;
	endtask : oob
	initial begin
		rx_burst = 1'b0;
		rx_prim = '0;
		rx_locked = 1'b0;
	end
	// A device sequence with reset spacing is answered by a wake sequence.
	always begin
		@(negedge clk);
		// While the host sends its own signal it disregards any bursts the device sends.
		if (sending) begin
			lo = 999;
			nb = 0;
		end else if (tx_ctl.burst) begin
			if (lo > 0) nb = (lo >= GAP_MIN_CYC && lo <= GAP_MAX_CYC) ? nb + 1 : 1;
			lo = 0;
		end else begin
			lo++;
		end
		if (lo == GAP_MAX_CYC + 2 && nb >= DET_BURSTS) begin
			nb = 0;
			oob(TX_BURSTS, WAKE_GAP_CYC);
		end
	end
	// The host answers the device's ALIGN only when answer is set and the speed matches ans_spd.
	assign ans = answer && tx_ctl.align && tx_ctl.speed == ans_spd;
	// Idle flag lines toggle so a stale value is never mistaken for a primitive.
	always @(negedge clk) begin
		ph <= ph + 2'h1;
		rx_locked <= ans || tx_ctl.sync;
		rx_prim <= '{valid: 1'b0, align: ph[0], sync: ph[1]};
		if (ph == 2'h0 && (ans || tx_ctl.sync)) begin
			rx_prim <= '{valid: 1'b1, align: ans, sync: !ans};
		end
	end
endmodule : sol_host_model

//--- bench/sol_link_init_tb_top.sv
// Self-checking bench for the device-side link bring-up against a host model.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
module sol_link_init_tb_top
	import sol_pkg::*;
();
	localparam int TMO = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rx_burst, rx_locked, cominit_req, answer, dev_reset, link_up, link_err;
	logic [SPD_W-1:0] ans_spd;
	sol_rx_prim_t rx_prim;
	sol_tx_ctl_t tx_ctl;
	int failures = 0;
	int n_checks = 0;
	int cnt, t_al, hi, lo, nb, gap, n;
	logic al_q = 1'b0;
	logic sp_q = 1'b0;
	logic saw_rst = 1'b0;
	always #4 clk = ~clk;
	sol_link_init #(.ALIGN_TMO_DW(TMO)) dut_u (.clk, .rst, .rx_burst, .rx_prim, .rx_locked,
		.cominit_req, .tx_ctl, .dev_reset, .link_up, .link_err);
	sol_host_model host_u (.clk, .tx_ctl, .answer, .ans_spd, .rx_burst, .rx_prim, .rx_locked);
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	function automatic logic sel(input int s);
		case (s)
			1: return link_up;
			2: return link_err;
			default: return dev_reset;
		endcase
	endfunction : sel
	task automatic wt(input int s, input int lim);
		int i;
		for (i = 0; i < lim && sel(s) !== 1'b1; i++) @(negedge clk);
		if (i == lim) begin
			chk("wait_done", 0, 1);
			results();
		end
	endtask : wt
	function automatic int tmo_cyc();
		return (TMO * DW_DEN + DW_NUM - 1) / DW_NUM;
	endfunction : tmo_cyc
	// Watches burst lengths, gaps, sequence counts and the speed fallback time.
	always @(posedge clk) begin
		cnt++;
		if (dev_reset === 1'b1) saw_rst = 1'b1;
		if (rst) begin
			hi = 0;
			lo = 999;
			nb = 0;
		end else if (tx_ctl.burst) begin
			if (hi == 0) begin
				if (lo < QUIET_CYC) chk("gap", lo == GAP_CYC || lo == WAKE_GAP_CYC, 1);
				nb = lo < QUIET_CYC ? nb + 1 : 1;
			end
			hi++;
			lo = 0;
		end else begin
			if (hi > 0) chk("burst_len", hi, BURST_CYC);
			hi = 0;
			lo++;
		end
		if (tx_ctl.align && !al_q) begin
			chk("wake_bursts", nb, TX_BURSTS);
			chk("top_speed", tx_ctl.speed, SPD_TOP);
			t_al = cnt;
		end
		if (al_q && sp_q && !tx_ctl.speed)
			chk("fallback", (cnt - t_al) inside {[tmo_cyc() - 3 : tmo_cyc() + 3]}, 1);
		al_q = tx_ctl.align;
		sp_q = tx_ctl.speed;
	end
	initial begin
		void'($urandom(95));
		{cominit_req, answer, ans_spd} = '0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		// The host resets the link right after system reset, over the late-start reply.
		host_u.oob(TX_BURSTS, GAP_CYC);
		chk("boot_reset", saw_rst, 1);
		// A host that answers with COMWAKE but never answers ALIGN: both speeds time out and the error holds.
		wt(2, 4000);
		repeat (100) @(negedge clk);
		chk("err_sticky", link_err, 1);
		chk("err_speed", tx_ctl.speed, 1'b0);
		chk("err_no_link", link_up, 0);
		// Device-initiated restart; host answers at the low speed, then at the top one.
		for (int k = 0; k < 2; k++) begin
			answer = 1'b1;
			ans_spd = k[SPD_W-1:0];
			cominit_req = 1'b1;
			@(negedge clk);
			cominit_req = 1'b0;
			repeat (2) @(negedge clk);
			chk("link_restart", link_up, 0);
			wt(1, 4000);
			chk("link_speed", tx_ctl.speed, ans_spd);
			chk("no_err", link_err, 0);
			chk("sync_sent", tx_ctl.sync, 1);
			chk("align_off", tx_ctl.align, 0);
		end
		// Host resets with random spacing; only a valid one may reset the device.
		for (int k = 0; k < 8; k++) begin
			saw_rst = 1'b0;
			case (k % 4)
				0: begin
					n = $urandom_range(7, 4);
					gap = $urandom_range(62, 24);
				end
				1: begin
					n = 3;
					gap = $urandom_range(62, 24);
				end
				2: begin
					n = 5;
					gap = $urandom_range(90, 70);
				end
				default: begin
					n = 5;
					gap = $urandom_range(4, 2);
				end
			endcase
			host_u.oob(n, gap);
			repeat (10) @(negedge clk);
			if (k % 4 == 0) begin
				chk("reset_seen", saw_rst, 1);
				chk("reset_rel", dev_reset, 0);
				chk("link_drop", link_up, 0);
				wt(1, 4000);
			end else begin
				chk("reset_seen", saw_rst, 0);
				chk("link_kept", link_up, 1);
			end
		end
		results();
	end
endmodule : sol_link_init_tb_top

//--- src/sol_link_init.sv
// Device-side out-of-band link initialisation and speed negotiation.
// Assumes a serialiser that sends a burst while tx_ctl.burst is high and primitives
// otherwise, and a receive decoder that flags each received primitive on this clock.
`timescale 1ns/1ps
module sol_link_init
	import sol_pkg::*;
#(
	parameter int ALIGN_TMO_DW = ALIGN_TMO_DWORDS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_burst,
	input wire sol_rx_prim_t rx_prim,
	input wire logic rx_locked,
	input wire logic cominit_req,
	output sol_tx_ctl_t tx_ctl,
	output logic dev_reset,
	output logic link_up,
	output logic link_err
);

	typedef enum logic [2:0] {
		ST_RESET, ST_INIT, ST_AWAIT, ST_WAKE, ST_ALIGN, ST_SYNC, ST_UP, ST_ERR
	} sol_state_t;

	sol_state_t state, next_state;
	logic rst_seen, rst_end, wake_end;
	logic tx_start, tx_busy, tx_on, tx_done;
	logic [2:0] tx_left;
	logic [7:0] tx_cnt, tx_gap;
	logic [3:0] dw_acc;
	logic dw_tick;
	logic [11:0] tmo;
	logic tmo_hit;
	logic [SPD_W-1:0] speed;
	logic [1:0] nonalign;
	logic rx_nonalign;

	sol_oob_det u_det (
		.clk(clk),
		.rst(rst),
		.rx_burst(rx_burst),
		.rst_seen(rst_seen),
		.rst_end(rst_end),
		.wake_end(wake_end)
	);

	// Fractional divider producing one tick per nominal Gen1 Dword.
	always_ff @(posedge clk) begin
		if (rst) begin
			dw_acc <= 4'h0;
			dw_tick <= 1'b0;
		end else if (dw_acc + DW_NUM >= DW_DEN) begin
			dw_acc <= dw_acc + DW_NUM - DW_DEN;
			dw_tick <= 1'b1;
		end else begin
			dw_acc <= dw_acc + DW_NUM;
			dw_tick <= 1'b0;
		end
	end

	assign rx_nonalign = rx_prim.valid && !rx_prim.align;
	assign tmo_hit = dw_tick && tmo == 12'(ALIGN_TMO_DW - 1);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESET: if (rst_end) next_state = ST_INIT;
			ST_INIT: if (tx_done) next_state = ST_AWAIT;
			ST_AWAIT: if (wake_end) next_state = ST_WAKE;
			ST_WAKE: if (tx_done) next_state = ST_ALIGN;
			ST_ALIGN: begin
				if (rx_prim.valid && rx_prim.align && rx_locked) begin
					next_state = ST_SYNC;
				end else if (tmo_hit && speed == '0) begin
					next_state = ST_ERR;
				end
			end
			ST_SYNC: if (rx_nonalign && nonalign == 2'(NONALIGN_RUN - 1)) next_state = ST_UP;
			ST_UP: next_state = ST_UP;
			ST_ERR: next_state = ST_ERR;
		endcase
		if (cominit_req && state != ST_RESET && state != ST_INIT) begin
			next_state = ST_INIT;
		end
		if (rst_seen) begin
			next_state = ST_RESET;
		end
	end

	// Power-up starts in ST_INIT so a late-starting device still announces itself.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	assign tx_start = (rst_end && !rst_seen) || (next_state != state
		&& (next_state == ST_WAKE || (next_state == ST_INIT && state != ST_RESET)));

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_gap <= 8'(GAP_CYC);
		end else if (tx_start) begin
			tx_gap <= (next_state == ST_WAKE) ? 8'(WAKE_GAP_CYC) : 8'(GAP_CYC);
		end
	end

	// Burst sequencer: six bursts, gaps between them, then a long quiet tail.
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_busy <= 1'b1;
			tx_on <= 1'b1;
			tx_left <= 3'(TX_BURSTS);
			tx_cnt <= 8'(BURST_CYC - 1);
		end else if (tx_start) begin
			tx_busy <= 1'b1;
			tx_on <= 1'b1;
			tx_left <= 3'(TX_BURSTS);
			tx_cnt <= 8'(BURST_CYC - 1);
		end else if (tx_busy) begin
			if (tx_cnt != CNT_RST) begin
				tx_cnt <= tx_cnt - 8'h01;
			end else if (tx_on) begin
				tx_on <= 1'b0;
				tx_left <= tx_left - 3'h1;
				tx_cnt <= (tx_left == 3'h1) ? 8'(QUIET_CYC - 1) : tx_gap - 8'h01;
			end else if (tx_left == 3'h0) begin
				tx_busy <= 1'b0;
			end else begin
				tx_on <= 1'b1;
				tx_cnt <= 8'(BURST_CYC - 1);
			end
		end
	end

	assign tx_done = tx_busy && !tx_on && tx_left == 3'h0 && tx_cnt == CNT_RST && !tx_start;

	// Per-speed timeout, counted in Dword ticks.
	always_ff @(posedge clk) begin
		if (rst || state != ST_ALIGN) begin
			tmo <= 12'h000;
		end else if (tmo_hit) begin
			tmo <= 12'h000;
		end else if (dw_tick) begin
			tmo <= tmo + 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state == ST_WAKE) begin
			speed <= SPD_TOP;
		end else if (state == ST_ALIGN && tmo_hit && speed != '0
			&& !(rx_prim.valid && rx_prim.align && rx_locked)) begin
			speed <= speed - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state != ST_SYNC || (rx_prim.valid && rx_prim.align)) begin
			nonalign <= 2'h0;
		end else if (rx_nonalign) begin
			nonalign <= nonalign + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_ctl <= '0;
			dev_reset <= 1'b0;
			link_up <= 1'b0;
			link_err <= 1'b0;
		end else begin
			tx_ctl.burst <= tx_busy && tx_on && !tx_start;
			tx_ctl.align <= state == ST_ALIGN;
			tx_ctl.sync <= state == ST_SYNC || state == ST_UP;
			tx_ctl.speed <= speed;
			dev_reset <= state == ST_RESET;
			link_up <= state == ST_UP;
			link_err <= state == ST_ERR;
		end
	end

	// Helper counters that only the checks read.
	logic [7:0] run_on, run_off;
	logic [2:0] sent;
	always_ff @(posedge clk) begin
		if (rst) begin
			run_on <= CNT_RST;
			run_off <= 8'hff;
			sent <= 3'h0;
		end else begin
			run_on <= tx_ctl.burst ? run_on + 8'h01 : CNT_RST;
			run_off <= tx_ctl.burst ? CNT_RST : ((run_off == 8'hff) ? run_off : run_off + 8'h01);
			sent <= tx_start ? 3'h0 : sent + 3'(tx_busy && tx_on && tx_cnt == CNT_RST);
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	sequence seq_fallback_due;
		state == ST_ALIGN && tmo_hit && !(rx_prim.valid && rx_prim.align && rx_locked);
	endsequence
	sequence seq_third_nonalign;
		state == ST_SYNC && rx_nonalign && nonalign == 2'h2 && !rst_seen && !cominit_req;
	endsequence

	chk_reset_hold: assert property (rst_seen |-> ##2 dev_reset)
		else $error("detected reset did not reset the device");
	chk_burst_len: assert property ($fell(tx_ctl.burst) |-> run_on == 8'(BURST_CYC))
		else $error("burst length wrong");
	chk_gap_len: assert property ($rose(tx_ctl.burst) |-> run_off == 8'(GAP_CYC)
		|| run_off == 8'(WAKE_GAP_CYC) || run_off >= 8'(QUIET_CYC))
		else $error("idle gap length wrong");
	chk_six_bursts: assert property (tx_done |-> sent == 3'(TX_BURSTS))
		else $error("sequence did not hold six bursts");
	chk_init_reply: assert property (rst_end && !rst_seen |-> ##[1:2] tx_ctl.burst)
		else $error("no reply after reset release");
	chk_speed_step: assert property (seq_fallback_due ##0 speed != '0
		|=> speed == $past(speed) - 1'b1)
		else $error("speed did not step down on timeout");
	chk_err_entry: assert property (seq_fallback_due ##0 speed == '0 && !rst_seen
		&& !cominit_req |=> ##1 link_err)
		else $error("lowest speed timeout did not raise error");
	chk_link_up: assert property (seq_third_nonalign |=> ##1 link_up && tx_ctl.sync)
		else $error("link not up after three non-align primitives");
	chk_sync_send: assert property (state == ST_SYNC |=> tx_ctl.sync && !tx_ctl.align)
		else $error("sync not sent once locked");

endmodule : sol_link_init

//--- src/sol_oob_det.sv
// Out-of-band receive detector: classifies burst spacing on the squelch pin.
// Assumes rx_burst is an asynchronous level from the analog squelch detector.
`timescale 1ns/1ps
module sol_oob_det
	import sol_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic rx_burst,
	output logic rst_seen,
	output logic rst_end,
	output logic wake_end
);

	logic s1, s2, s3, line, line_d;
	logic [7:0] idle;
	logic [2:0] cnt;
	logic kind_rst;
	logic gap_rst_ok, gap_wake_ok, rise;

	always_ff @(posedge clk) begin
		s1 <= rx_burst;
		s2 <= s1;
		s3 <= s2;
		if (rst) begin
			line <= 1'b0;
			line_d <= 1'b0;
		end else begin
			if (s2 == s3) begin
				line <= s2;
			end
			line_d <= line;
		end
	end

	assign rise = line && !line_d;
	assign gap_rst_ok = idle >= 8'(GAP_MIN_CYC) && idle <= 8'(GAP_MAX_CYC);
	assign gap_wake_ok = idle >= 8'(WAKE_MIN_CYC) && idle < 8'(GAP_MIN_CYC);

	always_ff @(posedge clk) begin
		if (rst || line) begin
			idle <= CNT_RST;
		end else if (idle != 8'hff) begin
			idle <= idle + 8'h01;
		end
	end

	// A gap longer than the window closes the sequence and reports what it was.
	always_ff @(posedge clk) begin
		rst_end <= 1'b0;
		wake_end <= 1'b0;
		if (rst) begin
			cnt <= 3'h0;
			kind_rst <= 1'b0;
		end else if (rise) begin
			if (cnt == 3'h0) begin
				cnt <= 3'h1;
			end else if (gap_rst_ok && (kind_rst || cnt == 3'h1)) begin
				kind_rst <= 1'b1;
				cnt <= (cnt == 3'h7) ? cnt : cnt + 3'h1;
			end else if (gap_wake_ok && (!kind_rst || cnt == 3'h1)) begin
				kind_rst <= 1'b0;
				cnt <= (cnt == 3'h7) ? cnt : cnt + 3'h1;
			end else begin
				cnt <= 3'h1;
				kind_rst <= 1'b0;
			end
		end else if (!line && idle == 8'(GAP_MAX_CYC + 1) && cnt != 3'h0) begin
			rst_end <= kind_rst && cnt >= 3'(DET_BURSTS);
			wake_end <= !kind_rst && cnt >= 3'(DET_BURSTS);
			cnt <= 3'h0;
			kind_rst <= 1'b0;
		end
	end

	assign rst_seen = kind_rst && cnt >= 3'(DET_BURSTS);

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	chk_four_bursts: assert property ($rose(rst_seen) |-> cnt == 3'(DET_BURSTS))
		else $error("reset detect raised on wrong burst count");
	chk_gap_invalid: assert property (rise && cnt != 3'h0 && !gap_rst_ok && !gap_wake_ok
		|=> !rst_seen && cnt == 3'h1)
		else $error("out-of-window gap did not invalidate detector");
	chk_end_pulse: assert property (rst_end |-> !wake_end ##1 !rst_end)
		else $error("sequence end pulse malformed");

endmodule : sol_oob_det

//--- src/sol_pkg.sv
// Shared constants and carrier types for the device-side out-of-band link bring-up.
// Assumes a single 125 MHz clock; out-of-band times are converted to cycles of that clock.
package sol_pkg;

	localparam int CLK_PS = 8000;

	// Out-of-band burst and gap times, and their cycle counts.
	localparam int BURST_PS = 106700;
	localparam int BURST_CYC = (BURST_PS + CLK_PS - 1) / CLK_PS;
	localparam int GAP_PS = 320000;
	localparam int GAP_CYC = (GAP_PS + CLK_PS - 1) / CLK_PS;
	localparam int WAKE_GAP_PS = 106700;
	localparam int WAKE_GAP_CYC = (WAKE_GAP_PS + CLK_PS - 1) / CLK_PS;
	localparam int GAP_MIN_PS = 175000;
	localparam int GAP_MIN_CYC = (GAP_MIN_PS + CLK_PS - 1) / CLK_PS;
	localparam int GAP_MAX_PS = 525000;
	localparam int GAP_MAX_CYC = GAP_MAX_PS / CLK_PS;
	localparam int WAKE_MIN_PS = 35000;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_PS + CLK_PS - 1) / CLK_PS;
	localparam int QUIET_PS = 525000;
	localparam int QUIET_CYC = (QUIET_PS + CLK_PS - 1) / CLK_PS;

	// Burst counts.
	localparam int DET_BURSTS = 4;
	localparam int TX_BURSTS = 6;

	// A Gen1 Dword lasts 80/3 ns, so three Dword ticks fall in every ten clocks.
	localparam logic [3:0] DW_NUM = 4'h3;
	localparam logic [3:0] DW_DEN = 4'ha;

	// Speed negotiation.
	localparam int ALIGN_TMO_PS = 54600000;
	localparam int ALIGN_TMO_DWORDS = 2048;
	localparam int NONALIGN_RUN = 3;
	localparam int SPD_W = 1;
	localparam logic [SPD_W-1:0] SPD_TOP = 1'h1;

	localparam logic [7:0] CNT_RST = 8'h00;

	typedef struct packed {
		logic valid;
		logic align;
		logic sync;
	} sol_rx_prim_t;

	typedef struct packed {
		logic burst;
		logic align;
		logic sync;
		logic [SPD_W-1:0] speed;
	} sol_tx_ctl_t;

endpackage : sol_pkg
